// ---- logic/usbep_flags.v ----
// Endpoint event flag registers and endpoint-0 transfer length counters.
`timescale 1ns/1ps
`include "usbep_regs.vh"

module usbep_flags (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [11:0] addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  input  wire [3:0]  tx_fifo_at_threshold_i,
  input  wire [3:0]  set_nak_effective_i,
  input  wire [3:0]  clear_nak_request_i,
  input  wire [3:0]  in_token_fifo_empty_i,
  input  wire [3:0]  ctrl_in_timeout_i,
  input  wire [3:0]  in_ep_disabled_i,
  input  wire [3:0]  in_xfer_done_i,
  input  wire [3:0]  out_ep_disabled_i,
  input  wire [3:0]  out_xfer_done_i,
  input  wire [3:0]  out_token_no_room_i,
  input  wire [3:0]  setup_rx_i,
  input  wire [3:0]  data_token_rx_i,
  input  wire        ep0_in_pkt_sent_i,
  input  wire        ep0_in_fifo_wr_done_i,
  input  wire [6:0]  ep0_in_fifo_wr_bytes_i,
  input  wire        ep0_out_pkt_rx_i,
  input  wire        ep0_out_fifo_rd_done_i,
  input  wire [6:0]  ep0_out_fifo_rd_bytes_i,
  output reg  [3:0]  out_drop_nak_o,
  output reg  [1:0]  ep0_in_packet_count_o,
  output reg         ep0_out_packet_count_o,
  output reg  [1:0]  ep0_setup_allowance_o
);

  wire [31:0] in_flags_rd;
  wire [31:0] out_flags_rd;
  wire [3:0]  in_hit;
  wire [3:0]  out_hit;
  wire        ep0_btb_event;
  reg  [6:0]  in_transfer_byte_total_q;
  reg  [6:0]  out_transfer_byte_total_q;
  reg  [6:0]  in_transfer_byte_total_d;
  reg  [6:0]  out_transfer_byte_total_d;
  reg  [1:0]  in_packet_count_d;
  reg         out_packet_count_d;
  reg  [1:0]  stp_d;
  reg  [31:0] rdata_d;
  wire        in_len_hit;
  wire        out_len_hit;
  wire        in_len_wr;
  wire        out_len_wr;
  reg  [7:0]  flag_rd_d;
  reg  [31:0] len_rd_d;

  assign in_len_hit  = (addr_i == `USBEP_IN0_LEN_OFF);
  assign out_len_hit = (addr_i == `USBEP_OUT0_LEN_OFF);
  assign in_len_wr   = wr_i && in_len_hit;
  assign out_len_wr  = wr_i && out_len_hit;

  genvar ep;
  generate
    for (ep = 0; ep < `USBEP_NUM_EP; ep = ep + 1) begin : g_ep
      reg  [7:0] in_q;
      reg  [7:0] out_q;
      reg  [7:0] in_d;
      reg  [7:0] out_d;
      reg  [2:0] btb_cnt_q;
      reg  [2:0] btb_cnt_d;
      reg        after_setup_q;
      wire [7:0] in_set;
      wire [7:0] out_set;
      reg  [7:0] in_clr;
      reg  [7:0] out_clr;
      wire       in_wr;
      wire       out_wr;
      wire       btb_hit;

      assign in_hit[ep]  = (addr_i == (`USBEP_IN_FLAGS_OFF +
                            (ep << `USBEP_EP_STRIDE_SH)));
      assign out_hit[ep] = (addr_i == (`USBEP_OUT_FLAGS_OFF +
                            (ep << `USBEP_EP_STRIDE_SH)));

      // Event inputs mapped onto the flag bits.
      assign in_set = {1'b0,
                       set_nak_effective_i[ep],
                       1'b0,
                       in_token_fifo_empty_i[ep],
                       ctrl_in_timeout_i[ep],
                       1'b0,
                       in_ep_disabled_i[ep],
                       in_xfer_done_i[ep]};

      assign btb_hit = setup_rx_i[ep] && (btb_cnt_q == `USBEP_BTB_LIMIT);
      assign out_set = {1'b0,
                        btb_hit | ((ep == 0) ? ep0_btb_event : 1'b0),
                        1'b0,
                        out_token_no_room_i[ep],
                        after_setup_q & data_token_rx_i[ep],
                        1'b0,
                        out_ep_disabled_i[ep],
                        out_xfer_done_i[ep]};

      assign in_wr  = wr_i && in_hit[ep];
      assign out_wr = wr_i && out_hit[ep];

      // Only a written one clears, or for bit 6 a clear-NAK request; the empty indication is never cleared by software.
      always @* begin
        in_clr  = 8'h00;
        out_clr = 8'h00;
        if (in_wr) begin
          in_clr = wdata_i[7:0] & `USBEP_IN_FLAGS_MASK & ~(8'h80);
        end
        if (out_wr) begin
          out_clr = wdata_i[7:0] & `USBEP_OUT_FLAGS_MASK;
        end
      end

      // IN flags: events set, written ones clear, bit 7 mirrors the FIFO level.
      always @* begin
        in_d = in_set | (in_q & ~in_clr);
        if (clear_nak_request_i[ep] && !set_nak_effective_i[ep]) begin
          in_d[`USBEP_FLG_NAKEFF] = 1'b0;
        end
        in_d[`USBEP_FLG_TX_FIFO_EMPTY_FLAG] = tx_fifo_at_threshold_i[ep];
        in_d = in_d & `USBEP_IN_FLAGS_MASK;
      end

      // OUT flags: events set, written ones clear.
      always @* begin
        out_d = (out_set | (out_q & ~out_clr)) & `USBEP_OUT_FLAGS_MASK;
      end

      // Consecutive SETUP counter; a data token breaks the run.
      always @* begin
        btb_cnt_d = btb_cnt_q;
        if (setup_rx_i[ep]) begin
          if (btb_cnt_q != `USBEP_BTB_LIMIT) begin
            btb_cnt_d = btb_cnt_q + 3'h1;
          end
        end else if (data_token_rx_i[ep]) begin
          btb_cnt_d = 3'h0;
        end
      end

      // IN flag register.
      always @(posedge clk_i) begin
        if (rst_i) begin
          in_q <= `USBEP_IN_FLAGS_RST;
        end else begin
          in_q <= in_d;
        end
      end

      // OUT flag register.
      always @(posedge clk_i) begin
        if (rst_i) begin
          out_q <= `USBEP_OUT_FLAGS_RST;
        end else begin
          out_q <= out_d;
        end
      end

      // Consecutive SETUP count.
      always @(posedge clk_i) begin
        if (rst_i) begin
          btb_cnt_q <= 3'h0;
        end else begin
          btb_cnt_q <= btb_cnt_d;
        end
      end

      // Remembers a SETUP whose phase no data token has ended yet.
      always @(posedge clk_i) begin
        if (rst_i) begin
          after_setup_q <= 1'b0;
        end else if (setup_rx_i[ep]) begin
          after_setup_q <= 1'b1;
        end else if (data_token_rx_i[ep]) begin
          after_setup_q <= 1'b0;
        end
      end

      assign in_flags_rd[ep*8 +: 8]  = in_q;
      assign out_flags_rd[ep*8 +: 8] = out_q;
    end
  endgenerate

  // Endpoint-0 SETUP allowance hitting zero raises the back-to-back flag.
  assign ep0_btb_event = setup_rx_i[0] && (ep0_setup_allowance_o == 2'h1);

  // Endpoint-0 IN packet count: a write loads it, each sent packet counts it down, stopping at zero.
  always @* begin
    in_packet_count_d = ep0_in_packet_count_o;
    if (in_len_wr) begin
      in_packet_count_d = wdata_i[`USBEP_IN_PACKET_COUNT_HI:`USBEP_IN_PACKET_COUNT_LO];
    end else if (ep0_in_pkt_sent_i && (ep0_in_packet_count_o != 2'h0)) begin
      in_packet_count_d = ep0_in_packet_count_o - 2'h1;
    end
  end

  // Endpoint-0 IN byte total: each finished FIFO write takes its bytes off.
  always @* begin
    in_transfer_byte_total_d = in_transfer_byte_total_q;
    if (in_len_wr) begin
      in_transfer_byte_total_d = wdata_i[`USBEP_TRANSFER_BYTE_TOTAL_HI:`USBEP_TRANSFER_BYTE_TOTAL_LO];
    end else if (ep0_in_fifo_wr_done_i) begin
      if (in_transfer_byte_total_q > ep0_in_fifo_wr_bytes_i) begin
        in_transfer_byte_total_d = in_transfer_byte_total_q - ep0_in_fifo_wr_bytes_i;
      end else begin
        in_transfer_byte_total_d = 7'h00;
      end
    end
  end

  // Endpoint-0 OUT packet count is one bit wide, so a received packet clears it.
  always @* begin
    out_packet_count_d = ep0_out_packet_count_o;
    if (out_len_wr) begin
      out_packet_count_d = wdata_i[`USBEP_OUT_PACKET_COUNT_BIT];
    end else if (ep0_out_pkt_rx_i) begin
      out_packet_count_d = 1'b0;
    end
  end

  // Endpoint-0 OUT byte total: each finished FIFO read takes its bytes off.
  always @* begin
    out_transfer_byte_total_d = out_transfer_byte_total_q;
    if (out_len_wr) begin
      out_transfer_byte_total_d = wdata_i[`USBEP_TRANSFER_BYTE_TOTAL_HI:`USBEP_TRANSFER_BYTE_TOTAL_LO];
    end else if (ep0_out_fifo_rd_done_i) begin
      if (out_transfer_byte_total_q > ep0_out_fifo_rd_bytes_i) begin
        out_transfer_byte_total_d = out_transfer_byte_total_q - ep0_out_fifo_rd_bytes_i;
      end else begin
        out_transfer_byte_total_d = 7'h00;
      end
    end
  end

  // Endpoint-0 SETUP allowance: each SETUP counts it down, stopping at zero.
  always @* begin
    stp_d = ep0_setup_allowance_o;
    if (out_len_wr) begin
      stp_d = wdata_i[`USBEP_STP_HI:`USBEP_STP_LO];
    end else if (setup_rx_i[0] && (ep0_setup_allowance_o != 2'h0)) begin
      stp_d = ep0_setup_allowance_o - 2'h1;
    end
  end

  // Flag register read-back, one endpoint at a time.
  always @* begin
    flag_rd_d = 8'h00;
    if (in_hit[0]) begin
      flag_rd_d = in_flags_rd[7:0];
    end else if (in_hit[1]) begin
      flag_rd_d = in_flags_rd[15:8];
    end else if (in_hit[2]) begin
      flag_rd_d = in_flags_rd[23:16];
    end else if (in_hit[3]) begin
      flag_rd_d = in_flags_rd[31:24];
    end else if (out_hit[0]) begin
      flag_rd_d = out_flags_rd[7:0];
    end else if (out_hit[1]) begin
      flag_rd_d = out_flags_rd[15:8];
    end else if (out_hit[2]) begin
      flag_rd_d = out_flags_rd[23:16];
    end else if (out_hit[3]) begin
      flag_rd_d = out_flags_rd[31:24];
    end
  end

  // Length register read-back; reserved bits read zero.
  always @* begin
    len_rd_d = 32'h00000000;
    if (in_len_hit) begin
      len_rd_d[`USBEP_IN_PACKET_COUNT_HI:`USBEP_IN_PACKET_COUNT_LO] = ep0_in_packet_count_o;
      len_rd_d[`USBEP_TRANSFER_BYTE_TOTAL_HI:`USBEP_TRANSFER_BYTE_TOTAL_LO]       = in_transfer_byte_total_q;
    end else if (out_len_hit) begin
      len_rd_d[`USBEP_STP_HI:`USBEP_STP_LO]   = ep0_setup_allowance_o;
      len_rd_d[`USBEP_OUT_PACKET_COUNT_BIT]           = ep0_out_packet_count_o;
      len_rd_d[`USBEP_TRANSFER_BYTE_TOTAL_HI:`USBEP_TRANSFER_BYTE_TOTAL_LO] = out_transfer_byte_total_q;
    end
  end

  // Register read mux; unmapped addresses read zero.
  always @* begin
    rdata_d = 32'h00000000;
    if (in_len_hit || out_len_hit) begin
      rdata_d = len_rd_d;
    end else begin
      rdata_d[7:0] = flag_rd_d;
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= rd_i ? rdata_d : 32'h00000000;
    end
  end

  // Drop-and-NAK answer follows an overrun by one cycle.
  always @(posedge clk_i) begin
    if (rst_i) begin
      out_drop_nak_o <= 4'h0;
    end else begin
      out_drop_nak_o <= out_token_no_room_i;
    end
  end

  // Endpoint-0 IN packet count.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ep0_in_packet_count_o <= 2'h0;
    end else begin
      ep0_in_packet_count_o <= in_packet_count_d;
    end
  end

  // Endpoint-0 OUT packet count.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ep0_out_packet_count_o <= 1'b0;
    end else begin
      ep0_out_packet_count_o <= out_packet_count_d;
    end
  end

  // Endpoint-0 SETUP allowance.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ep0_setup_allowance_o <= 2'h0;
    end else begin
      ep0_setup_allowance_o <= stp_d;
    end
  end

  // Endpoint-0 IN byte total.
  always @(posedge clk_i) begin
    if (rst_i) begin
      in_transfer_byte_total_q <= 7'h00;
    end else begin
      in_transfer_byte_total_q <= in_transfer_byte_total_d;
    end
  end

  // Endpoint-0 OUT byte total.
  always @(posedge clk_i) begin
    if (rst_i) begin
      out_transfer_byte_total_q <= 7'h00;
    end else begin
      out_transfer_byte_total_q <= out_transfer_byte_total_d;
    end
  end

endmodule // usbep_flags

// ---- shared/usbep_regs.vh ----
// Register map, field positions, reset values and counts of the endpoint flag block.
`ifndef USBEP_REGS_VH
`define USBEP_REGS_VH

`define USBEP_NUM_EP          4
`define USBEP_ADDR_W          12
`define USBEP_EP_STRIDE_SH    5

`define USBEP_IN_FLAGS_OFF    12'h908
`define USBEP_IN0_LEN_OFF     12'h910
`define USBEP_OUT_FLAGS_OFF   12'hb08
`define USBEP_OUT0_LEN_OFF    12'hb10

`define USBEP_IN_FLAGS_RST    8'h80
`define USBEP_OUT_FLAGS_RST   8'h00
`define USBEP_LEN_RST         32'h00000000

`define USBEP_FLG_TX_FIFO_EMPTY_FLAG        7
`define USBEP_FLG_NAKEFF      6
`define USBEP_FLG_BTB         6
`define USBEP_FLG_FIFO_ERR    4
`define USBEP_FLG_TIMEOUT     3
`define USBEP_FLG_SETUP_DONE  3
`define USBEP_FLG_ENDPOINT_DISABLED_FLAG       1
`define USBEP_FLG_XFER_DONE   0

`define USBEP_IN_FLAGS_MASK   8'hdb
`define USBEP_OUT_FLAGS_MASK  8'h5b

`define USBEP_IN_PACKET_COUNT_HI      20
`define USBEP_IN_PACKET_COUNT_LO      19
`define USBEP_OUT_PACKET_COUNT_BIT    19
`define USBEP_STP_HI          30
`define USBEP_STP_LO          29
`define USBEP_TRANSFER_BYTE_TOTAL_HI         6
`define USBEP_TRANSFER_BYTE_TOTAL_LO         0

`define USBEP_BTB_LIMIT       3'h3

`endif

// ---- tb/usbep_flags_tb.sv ----
// Self-checking bench of the endpoint flag block.
`timescale 1ns/1ps
module usbep_flags_tb;
  localparam [63:0] TBL = 64'h6843341a0bc29c8d;
  reg         clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, go = 0, wdn = 0, rdn = 0;
  reg  [11:0] addr_i = 0, a;
  reg  [31:0] wdata_i = 0, x;
  reg  [3:0]  thr = 4'hf, nak = 0, clear_nak_request = 0, idis = 0, idone = 0, odis = 0, odone = 0;
  reg  [2:0]  kind = 0;
  reg  [1:0]  ep = 0, e;
  reg  [6:0]  wb = 0, rb = 0, nb = 0;
  reg  [7:0]  t;
  reg  [15:0] r = 16'd26037;
  integer     errors = 0, tests_run = 0, i, j, p, tl;
  wire [31:0] rdata_o;
  wire [3:0]  drop, stu, tok, nrm, ie, hl;
  wire [1:0]  ipc, stp;
  wire        opc, snt, rxp;
  usbep_host host (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .kind_i(kind), .ep_i(ep),
    .st_o(stu), .tk_o(tok), .nr_o(nrm), .ie_o(ie), .hl_o(hl), .sn_o(snt), .rx_o(rxp));
  usbep_flags uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_fifo_at_threshold_i(thr),
    .set_nak_effective_i(nak), .clear_nak_request_i(clear_nak_request), .in_token_fifo_empty_i(ie),
    .ctrl_in_timeout_i(hl), .in_ep_disabled_i(idis), .in_xfer_done_i(idone),
    .out_ep_disabled_i(odis), .out_xfer_done_i(odone), .out_token_no_room_i(nrm),
    .setup_rx_i(stu), .data_token_rx_i(tok), .ep0_in_pkt_sent_i(snt),
    .ep0_in_fifo_wr_done_i(wdn), .ep0_in_fifo_wr_bytes_i(wb), .ep0_out_pkt_rx_i(rxp),
    .ep0_out_fifo_rd_done_i(rdn), .ep0_out_fifo_rd_bytes_i(rb), .out_drop_nak_o(drop),
    .ep0_in_packet_count_o(ipc), .ep0_out_packet_count_o(opc), .ep0_setup_allowance_o(stp));
  function [15:0] lf(input [15:0] s);
    lf = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task results;
    begin
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] ex);
    begin
      tests_run = tests_run + 1;
      if (g !== ex) begin
        errors = errors + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, g, ex);
      end
    end
  endtask
  task wr(input [11:0] ad, input [31:0] d);
    begin
      @(posedge clk_i) {wr_i, addr_i, wdata_i} <= {1'b1, ad, d};
      @(posedge clk_i) wr_i <= 0;
    end
  endtask
  task rd(input [11:0] ad, input [31:0] ex);
    begin
      @(posedge clk_i) {rd_i, addr_i} <= {1'b1, ad};
      @(posedge clk_i) rd_i <= 0;
      #1 chk(rdata_o, ex);
    end
  endtask
  task ev(input [3:0] k, input [1:0] en);
    begin
      @(posedge clk_i) {go, kind, ep, wb, rb} <= {!k[3], k[2:0], en, nb, nb};
      {wdn, rdn} <= {k == 4'he, k == 4'hf};
      {nak, clear_nak_request, idis, idone, odis, odone} <= k[3] ? 24'h1 << (20 - 4 * k[2:0] + en) : 24'h0;
      @(posedge clk_i) {go, wdn, rdn} <= 3'h0;
      {nak, clear_nak_request, idis, idone, odis, odone} <= 24'h0;
      @(posedge clk_i) #1;
    end
  endtask
  initial forever #10 clk_i = !clk_i;
  initial begin
    #1000000 errors = errors + 1;
    results;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    for (i = 0; i < 4; i = i + 1) begin
      rd(12'h908 + {i[1:0], 5'h0}, 32'h80);
      rd(12'hb08 + {i[1:0], 5'h0}, 32'h0);
    end
    rd(12'h910, 32'h0);
    rd(12'hb10, 32'h0);
    rd(12'h90c, 32'h0);
    for (i = 0; i < 8; i = i + 1) begin
      r = lf(r);
      e = r[1:0];
      t = TBL[8*i +: 8];
      @(posedge clk_i) thr <= r[7:4];
      a = (t[7] ? 12'hb08 : 12'h908) + {e, 5'h0};
      ev(t[3:0], e);
      x = t[7] ? 32'h0 : {24'h0, thr[e], 7'h0};
      rd(a, x | (32'h1 << t[6:4]));
      wr(a, 32'h0);
      rd(a, x | (32'h1 << t[6:4]));
      wr(a, 32'hffffffff);
      rd(a, x);
    end
    ev(4'h8, 2'h0);
    ev(4'h9, 2'h0);
    rd(12'h908, {24'h0, thr[0], 7'h0});
    ev(4'h0, e);
    ev(4'h1, e);
    rd(12'hb08 + {e, 5'h0}, 32'h08);
    wr(12'hb08 + {e, 5'h0}, 32'hff);
    for (j = 0; j < 4; j = j + 1) ev(4'h0, e);
    rd(12'hb08 + {e, 5'h0}, 32'h40);
    wr(12'h910, 32'hffffffff);
    rd(12'h910, 32'h0018007f);
    wr(12'h910, 32'h00180064);
    p = 3;
    tl = 100;
    for (i = 0; i < 4; i = i + 1) begin
      r = lf(r);
      nb = r[5:0] + 7'h10;
      ev(4'h5, 2'h0);
      ev(4'he, 2'h0);
      p = p ? p - 1 : 0;
      tl = tl > nb ? tl - nb : 0;
      chk(ipc, p);
      rd(12'h910, (p << 19) | tl);
    end
    ev(4'h1, 2'h0);
    wr(12'hb08, 32'hff);
    wr(12'hb10, 32'h60080050);
    for (j = 3; j > 0; j = j - 1) begin
      ev(4'h0, 2'h0);
      chk(stp, j - 1);
    end
    rd(12'hb08, 32'h40);
    ev(4'h6, 2'h0);
    chk(opc, 0);
    nb = 7'h30;
    ev(4'hf, 2'h0);
    rd(12'hb10, 32'h20);
    ev(4'hf, 2'h0);
    rd(12'hb10, 32'h0);
    results;
  end
endmodule // usbep_flags_tb

// ---- tb/usbep_host.sv ----
// Behavioural USB host issuing one token or packet event per request.
`timescale 1ns/1ps
module usbep_host (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       go_i,
  input  wire [2:0] kind_i,
  input  wire [1:0] ep_i,
  output reg  [3:0] st_o,
  output reg  [3:0] tk_o,
  output reg  [3:0] nr_o,
  output reg  [3:0] ie_o,
  output reg  [3:0] hl_o,
  output reg        sn_o,
  output reg        rx_o
);
  wire [3:0] s = (go_i && !rst_i) ? 4'h1 << ep_i : 4'h0;
  always @(posedge clk_i) begin
    {st_o, tk_o, nr_o, ie_o, hl_o} <= {16'h0, s} << (4 * (3'h4 - kind_i));
    sn_o <= s[0] && kind_i == 3'h5;
    rx_o <= s[0] && kind_i == 3'h6;
  end
endmodule // usbep_host

// ---- tb/usbep_props.sv ----
// Port checker of the endpoint flag block.
`timescale 1ns/1ps
module usbep_props (
  input wire        clk_i,
  input wire        rst_i,
  input wire [11:0] addr_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [31:0] rdata_o,
  input wire [3:0]  tx_fifo_at_threshold_i,
  input wire [3:0]  out_token_no_room_i,
  input wire [3:0]  setup_rx_i,
  input wire        ep0_in_pkt_sent_i,
  input wire        ep0_out_pkt_rx_i,
  input wire [3:0]  out_drop_nak_o,
  input wire [1:0]  ep0_in_packet_count_o,
  input wire        ep0_out_packet_count_o,
  input wire [1:0]  ep0_setup_allowance_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  drop_nak_a: assert property (out_token_no_room_i != 4'h0 |=>
    out_drop_nak_o == $past(out_token_no_room_i)) else $error("drop not answered");
  drop_cause_a: assert property (out_drop_nak_o != 4'h0 |->
    out_drop_nak_o == $past(out_token_no_room_i)) else $error("drop without cause");
  in_packet_count_dec_a: assert property (ep0_in_pkt_sent_i && !wr_i &&
    ep0_in_packet_count_o != 2'h0
    |=> ep0_in_packet_count_o == $past(ep0_in_packet_count_o) - 2'h1) else $error("in count");
  in_packet_count_hold_a: assert property (!wr_i && !ep0_in_pkt_sent_i |=>
    $stable(ep0_in_packet_count_o)) else $error("in count moved");
  out_packet_count_clr_a: assert property (ep0_out_pkt_rx_i && !wr_i |=>
    !ep0_out_packet_count_o) else $error("out count");
  stp_dec_a: assert property (setup_rx_i[0] && !wr_i && ep0_setup_allowance_o != 2'h0
    |=> ep0_setup_allowance_o == $past(ep0_setup_allowance_o) - 2'h1) else $error("allowance");
  stp_hold_a: assert property (!wr_i && !setup_rx_i[0] |=>
    $stable(ep0_setup_allowance_o)) else $error("allowance moved");
  reset_zero_a: assert property ($fell(rst_i) |-> ep0_in_packet_count_o == 2'h0 &&
    ep0_setup_allowance_o == 2'h0 && !ep0_out_packet_count_o && out_drop_nak_o == 4'h0)
    else $error("reset values");
  tx_fifo_empty_flag_read_a: assert property (rd_i && addr_i == 12'h908 && !$past(rst_i) |=>
    rdata_o[7] == $past(tx_fifo_at_threshold_i[0], 2)) else $error("fifo empty bit");
  drop_c: cover property (out_drop_nak_o != 4'h0);
  stp_zero_c: cover property (setup_rx_i[0] && ep0_setup_allowance_o == 2'h1);
  read_c: cover property (rd_i && addr_i == 12'h908);
endmodule // usbep_props
bind usbep_flags usbep_props u_props (.*);
